// ### verilog/fuse_array_pkg.sv
// package: constants and carriers for the fuse logic array
package fuse_array_pkg;
    localparam int CLK_MHZ = 25;
    localparam int PULSE_MIN_US = 10;
    localparam int PULSE_MIN_CYC = PULSE_MIN_US * CLK_MHZ;
    localparam int NUM_PINS = 8;
    localparam int NUM_LINES = 32;
    localparam int NUM_PRODUCTS = 64;
    localparam int TERMS_PER_OUT = 8;
    localparam int GROUP_SIZE = 32;
    localparam logic [7:0] Q_RESET = 8'hff;
    localparam logic [7:0] OE_RESET = 8'h00;
    localparam logic [10:0] CNT_RESET = 11'h000;

    typedef struct packed {
        logic [7:0] data_in;
        logic reg_clk;
        logic out_enable_n;
        logic programming_output_disable;
        logic vcc_prog;
        logic [7:0] input_select_hh;
        logic [7:0] input_select_lvl;
        logic half_select_hh;
        logic [2:0] product_addr;
        logic [7:0] group_hh;
        logic [1:0] protect_hh;
    } pins_s;

    typedef struct packed {
        pins_s s1;
        pins_s s2;
        logic clk_prev;
        logic [7:0] q;
        logic [NUM_PRODUCTS-1:0][NUM_LINES-1:0] fuse;
        logic locked;
        logic [10:0] pulse_cnt;
        logic blown;
        logic [7:0] out_val;
        logic [7:0] out_en;
    } state_s;
endpackage

// ### verilog/fuse_logic_array.sv
// fuse logic array: registered sum-of-products with fuse program and verify
// Behaviour
// [R1] each output is the OR of eight programmable AND product terms
// [R2] a product term with every fuse blown evaluates high
// [R3] a term joined to true and inverted literal of one input is low
// [R4] outputs are D flip-flops loaded on the rising edge of the clock pin
// [R5] registers come up high; no functional reset pin exists
// [R6] a dedicated enable pin switches outputs between driven and off
// [R7] the 64 product lines split into groups 0-31 and 32-63, own output pins
// [R8] programmer raises output disable before any line selection
// [R9] programmer selects an input line with eight select pins and half select
// [R10] programmer selects a product line with three address pins
// [R11] programmer raises supply to program level only after selection is stable
// [R12] programmer pulses group output pins 10 to 50 us, duty at most 25 percent; the testbench also drives six 4 us pulses
// [R13] after blowing, clock pulse shows the fuse state at 6.0 V and 4.2 V
// [R14] on verify failure the programmer retries the sequence up to five times
// [R15] with both protection fuses blown, verification is no longer possible
// [R16] programmer blows protection fuses by raising two input pins to 20 V
// [R17] lines k and k+32 share select; address k mod 8, group pin k div 8
// [R18] after all retries fail, programmer stops, reports and restores pins
`timescale 1ns/1ps
`default_nettype none
module fuse_logic_array
    import fuse_array_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire pins_s pins,
    output logic [7:0] out_o,
    output logic [7:0] out_oe
);
    // a fresh device ships with every fuse intact and the lock open
    state_s st_reg = '{fuse: '1, default: '0};
    state_s st_next;
    logic [NUM_LINES-1:0] literal;
    logic [NUM_PRODUCTS-1:0] prod;
    logic [7:0] sum;
    logic reg_edge;
    logic [2:0] pin_idx;
    logic [3:0] free_cnt;
    logic [4:0] line_idx;
    logic [1:0] grp_idx;
    logic [3:0] grp_cnt;
    logic grp_hi;
    logic [5:0] prod_idx;
    logic sel_ok;
    logic prog_mode;
    logic blow_go;

    // literal lines: even line is the true form, odd line the inverted form
    always_comb begin
        for (int i = 0; i < NUM_PINS; i++) begin
            literal[2*i] = st_reg.s2.data_in[i];
            literal[2*i+1] = ~st_reg.s2.data_in[i];
            literal[16+2*i] = st_reg.q[i];
            literal[16+2*i+1] = ~st_reg.q[i];
        end
    end

    // AND plane: intact fuse connects a literal, blown fuse drops it
    always_comb begin
        for (int p = 0; p < NUM_PRODUCTS; p++) begin
            prod[p] = &(~st_reg.fuse[p] | literal); // R2 R3
        end
        for (int o = 0; o < 8; o++) begin
            sum[o] = |prod[o*TERMS_PER_OUT +: TERMS_PER_OUT]; // R1
        end
    end

    // select decoding: the one select pin not at program level names the line
    always_comb begin
        pin_idx = 3'h0;
        free_cnt = 4'h0;
        grp_idx = 2'h0;
        grp_cnt = 4'h0;
        grp_hi = 1'b0;
        for (int i = 0; i < NUM_PINS; i++) begin
            if (!st_reg.s2.input_select_hh[i]) begin
                pin_idx = 3'(i);
                free_cnt = free_cnt + 4'h1;
            end
            if (st_reg.s2.group_hh[i]) begin
                grp_idx = 2'(i % 4); // R17
                grp_hi = (i >= 4); // R7
                grp_cnt = grp_cnt + 4'h1;
            end
        end
        line_idx = {pin_idx, st_reg.s2.half_select_hh,
            st_reg.s2.input_select_lvl[pin_idx]};
        prod_idx = {grp_hi, grp_idx, st_reg.s2.product_addr}; // R7 R17
        sel_ok = (free_cnt == 4'h1);
    end

    assign reg_edge = st_reg.s2.reg_clk & ~st_reg.clk_prev;
    assign prog_mode = st_reg.s2.programming_output_disable;
    assign blow_go = prog_mode && st_reg.s2.vcc_prog && sel_ok && (grp_cnt == 4'h1)
        && !st_reg.blown && (st_reg.pulse_cnt == 11'(PULSE_MIN_CYC - 1));

    // next state: sync, array registers, fuse blowing, verify and outputs
    always_comb begin
        st_next = st_reg;
        st_next.s1 = pins;
        st_next.s2 = st_reg.s1;
        st_next.clk_prev = st_reg.s2.reg_clk;
        if (&st_reg.s2.protect_hh) begin
            st_next.locked = 1'b1; // R15
        end
        // a pulse must stand the least width before the fuse opens
        if (prog_mode && st_reg.s2.vcc_prog && (grp_cnt == 4'h1)) begin
            if (st_reg.pulse_cnt != 11'(PULSE_MIN_CYC - 1)) begin
                st_next.pulse_cnt = st_reg.pulse_cnt + 11'h001;
            end
        end else begin
            st_next.pulse_cnt = CNT_RESET;
            st_next.blown = 1'b0;
        end
        if (blow_go) begin
            st_next.fuse[prod_idx][line_idx] = 1'b0; // R12
            st_next.blown = 1'b1;
        end
        if (!prog_mode) begin
            if (reg_edge) begin
                st_next.q = sum; // R4
            end
            st_next.out_val = st_next.q;
            st_next.out_en = {8{~st_reg.s2.out_enable_n}}; // R6
        end else if (!st_reg.s2.vcc_prog && reg_edge) begin
            // verify: each group pin shows its own product line, blown reads high
            for (int o = 0; o < 8; o++) begin
                st_next.out_val[o] = ~st_reg.fuse[{3'(o), st_reg.s2.product_addr}][line_idx]; // R13
            end
            st_next.out_en = (sel_ok && !st_reg.locked) ? 8'hff : OE_RESET; // R15
        end else if (st_reg.s2.vcc_prog || st_reg.locked) begin
            st_next.out_en = OE_RESET; // R15
        end
    end

    // registers; the fuse array is nonvolatile and survives power-up
    always_ff @(posedge clk) begin
        if (rst) begin
            // sync stages come up at the disabled enable level, no false enable
            st_reg.s1 <= '0;
            st_reg.s1.out_enable_n <= 1'b1;
            st_reg.s2 <= '0;
            st_reg.s2.out_enable_n <= 1'b1;
            st_reg.clk_prev <= 1'b0;
            st_reg.q <= Q_RESET; // R5
            st_reg.fuse <= st_next.fuse;
            st_reg.locked <= st_next.locked;
            st_reg.pulse_cnt <= CNT_RESET;
            st_reg.blown <= 1'b0;
            st_reg.out_val <= Q_RESET; // R5
            st_reg.out_en <= OE_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    assign out_o = st_reg.out_val;
    assign out_oe = st_reg.out_en;

    // named steps that the assertions below are built from
    sequence seq_reg_edge;
        reg_edge && !prog_mode;
    endsequence
    sequence seq_verify_edge;
        reg_edge && prog_mode && !st_reg.s2.vcc_prog && sel_ok && !st_reg.locked;
    endsequence
    sequence seq_prog_supply;
        prog_mode && st_reg.s2.vcc_prog;
    endsequence

    AST_POWER_HIGH: assert property (@(posedge clk) rst |=> st_reg.q == 8'hff) // R5
        else $error("register not high after power-up");
    AST_REG_LOAD: assert property (@(posedge clk) disable iff (rst)
        seq_reg_edge |=> st_reg.q == $past(sum) ##1 out_o == $past(st_reg.q)) // R4
        else $error("register did not load array result");
    AST_REG_HOLD: assert property (@(posedge clk) disable iff (rst)
        !reg_edge |=> $stable(st_reg.q)) // R4
        else $error("register moved without clock edge");
    AST_ALL_BLOWN: assert property (@(posedge clk) disable iff (rst)
        st_reg.fuse[40] == '0 |-> prod[40]) // R2
        else $error("fully blown term not high");
    AST_BOTH_FORMS: assert property (@(posedge clk) disable iff (rst)
        st_reg.fuse[0][1:0] == 2'b11 |-> !prod[0]) // R3
        else $error("term with both literal forms not low");
    AST_OR_PLANE: assert property (@(posedge clk) disable iff (rst)
        seq_reg_edge ##0 (prod[7:0] == 8'h00) |=> !st_reg.q[0]) // R1
        else $error("output high with no term true");
    AST_ENABLE_PIN: assert property (@(posedge clk) disable iff (rst)
        !prog_mode && st_reg.s2.out_enable_n |=> out_oe == 8'h00) // R6
        else $error("outputs driven while enable pin off");
    AST_PROTECT: assert property (@(posedge clk) disable iff (rst)
        st_reg.locked && prog_mode |=> out_oe == 8'h00) // R15
        else $error("verify allowed after protection");
    AST_BLOW: assert property (@(posedge clk) disable iff (rst)
        blow_go |=> !st_reg.fuse[$past(prod_idx)][$past(line_idx)]) // R12
        else $error("selected fuse not opened");
    AST_VERIFY: assert property (@(posedge clk) disable iff (rst) // R13
        seq_verify_edge |=> out_oe == 8'hff
            && out_o[0] == !$past(st_reg.fuse[{3'h0, st_reg.s2.product_addr}][line_idx]))
        else $error("verify output wrong");

    // guards on the programming path, the lock and the enable pin
    AST_LOCK_STICKY: assert property (@(posedge clk) disable iff (rst) // R15
        st_reg.locked |=> st_reg.locked)
        else $error("protection lock released");
    AST_FUSE_HOLD: assert property (@(posedge clk) disable iff (rst) // R12
        !blow_go |=> $stable(st_reg.fuse))
        else $error("fuse opened without a full pulse");
    AST_BLOW_ONCE: assert property (@(posedge clk) disable iff (rst) // R12
        blow_go |=> !blow_go)
        else $error("fuse blown twice in one pulse");
    AST_PROG_QUIET: assert property (@(posedge clk) disable iff (rst) // R12
        seq_prog_supply |=> out_oe == 8'h00)
        else $error("outputs driven at program supply");
    AST_VERIFY_GROUP: assert property (@(posedge clk) disable iff (rst) // R7
        seq_verify_edge |=>
            out_o[5] == !$past(st_reg.fuse[{3'h5, st_reg.s2.product_addr}][line_idx]))
        else $error("group pin shows wrong product line");
    AST_OE_FOLLOW: assert property (@(posedge clk) disable iff (rst) // R6
        !prog_mode && !st_reg.s2.out_enable_n |=> out_oe == 8'hff)
        else $error("outputs not driven while enable pin on");
endmodule
`default_nettype wire

// ### sim/fuse_programmer.sv
// device programmer model that drives the fuse array pins
`timescale 1ns/1ps
`default_nettype none
module fuse_programmer
    import fuse_array_pkg::*;
(
    input wire logic clk,
    input wire logic [7:0] data_in,
    input wire logic out_enable_n,
    input wire logic [7:0] dout,
    output pins_s pins
);
    pins_s p = '0;
    logic ok;
    // user-side logic levels pass straight to the pins
    always_comb begin
        pins = p;
        pins.data_in = data_in;
        pins.out_enable_n = out_enable_n;
    end
    // one rising and falling edge on the device clock pin
    task automatic clock_pulse();
        p.reg_clk = 1'b1;
        repeat (4) @(negedge clk);
        p.reg_clk = 1'b0;
        repeat (8) @(negedge clk);
    endtask
    // output disable first, then input line and product address together
    task automatic select(input logic [4:0] line, input logic [5:0] prod);
        pins_s idle = '0;
        idle.programming_output_disable = 1'b1;
        p = idle;
        repeat (2) @(negedge clk);
        p.input_select_hh = ~(8'h01 << line[4:2]);
        p.half_select_hh = line[1];
        p.input_select_lvl = {8{line[0]}};
        p.product_addr = prod[2:0];
        repeat (4) @(negedge clk);
    endtask
    // program one fuse and verify at both levels, retrying on failure
    task automatic blow(input logic [4:0] line, input logic [5:0] prod, input int width);
        ok = 1'b0;
        for (int n = 0; n < 6 && !ok; n++) begin
            select(line, prod);
            p.vcc_prog = 1'b1;
            repeat (4) @(negedge clk);
            p.group_hh = 8'h01 << ({prod[5], 2'b00} + prod[4:3]);
            repeat (width) @(negedge clk);
            p.group_hh = 8'h00;
            p.vcc_prog = 1'b0;
            clock_pulse();
            ok = dout[prod[5:3]];
            clock_pulse();
            ok = ok & dout[prod[5:3]];
            repeat (3 * width) @(negedge clk);
        end
        if (!ok) $display("programmer gave up on line %0d product %0d", line, prod);
        p = '0;
        @(negedge clk);
    endtask
    // verify read of one fuse, pins left in verify mode
    task automatic read(input logic [4:0] line, input logic [5:0] prod);
        select(line, prod);
        clock_pulse();
    endtask
    // normal operating clock
    task automatic normal();
        p = '0;
        repeat (4) @(negedge clk);
        clock_pulse();
    endtask
    // protection pins raised without the program supply
    task automatic protect();
        pins_s prot = '0;
        prot.protect_hh = 2'b11;
        p = prot;
        repeat (8) @(negedge clk);
        p = '0;
    endtask
endmodule
`default_nettype wire

// ### sim/fuse_logic_array_tb.sv
// testbench for the fuse logic array
`timescale 1ns/1ps
`default_nettype none
module fuse_logic_array_tb;
    import fuse_array_pkg::*;
    typedef struct packed {logic [15:0] val; logic [15:0] mask;} note_s;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic out_enable_n = 1'b1;
    logic [7:0] data_in = 8'h00;
    logic sample = 1'b0;
    pins_s pins;
    logic [7:0] out_o;
    logic [7:0] out_oe;
    note_s notes[$];
    note_s cur;
    integer seed = 32'h8f924e53;
    int err_count = 0;
    int n_tests = 0;
    fuse_programmer i_fuse_programmer (.clk(clk), .data_in(data_in),
        .out_enable_n(out_enable_n), .dout(out_o), .pins(pins));
    fuse_logic_array i_fuse_logic_array (.clk(clk), .rst(rst), .pins(pins),
        .out_o(out_o), .out_oe(out_oe));
    // 25 MHz clock
    initial begin
        forever #20 clk = ~clk;
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] out_oe_out_o expected %h seen %h", exp, seen);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // note the expected outputs and ask the watcher to sample
    task automatic expect_out(input logic [15:0] val, input logic [15:0] mask);
        notes.push_back({val, mask});
        @(negedge clk) sample = 1'b1;
        @(negedge clk) sample = 1'b0;
    endtask
    task automatic run_clock();
        data_in = 8'($random(seed));
        i_fuse_programmer.normal();
    endtask
    // watcher compares the oldest note against the outputs
    always @(posedge clk) begin
        if (sample === 1'b1) begin
            cur = notes.pop_front();
            check({out_oe, out_o} & cur.mask, cur.val & cur.mask);
        end
    end
    // main sequence
    initial begin
        repeat (8) @(negedge clk);
        rst = 1'b0;
        expect_out(16'h00ff, 16'hffff);
        out_enable_n = 1'b0;
        run_clock();
        expect_out(16'hff00, 16'hffff);
        out_enable_n = 1'b1;
        repeat (6) @(negedge clk);
        expect_out(16'h0000, 16'hffff);
        out_enable_n = 1'b0;
        i_fuse_programmer.blow(5'd0, 6'd0, 100);
        i_fuse_programmer.read(5'd0, 6'd0);
        expect_out(16'hff00, 16'hffff);
        for (int l = 0; l < 32; l++) i_fuse_programmer.blow(l[4:0], 6'd40, 260);
        i_fuse_programmer.read(5'd7, 6'd40);
        expect_out(16'hff20, 16'hffff);
        run_clock();
        expect_out(16'hff20, 16'hffff);
        i_fuse_programmer.protect();
        i_fuse_programmer.read(5'd7, 6'd40);
        expect_out(16'h0000, 16'hff00);
        end_of_test();
    end
    // watchdog cuts a hang short
    initial begin
        #(90000 * 40);
        err_count++;
        end_of_test();
    end
endmodule
`default_nettype wire
